/* logic/sae_defs.vh */
// How it works
// (RULE1) A set sign-extend control widens each word read from the receive FIFO by copying its top bit upward.
// (RULE2) A frame error raises the frame error event only while its event enable is set.
// (RULE3) A receive overflow raises the overflow event only while its event enable is set.
// (RULE4) A transmit underrun raises the underrun event only while its event enable is set.
// (RULE5) With overflow ignored, an overflow keeps the link running and the new word is dropped, not written over old data.
// (RULE6) With overflow not ignored, an overflow halts serial operation.
// (RULE7) With underrun ignored, an underrun keeps running and zeros are shifted out until the buffer is refilled.
// (RULE8) With underrun not ignored, an underrun halts serial operation.
// (RULE9) The audio enable selects codec framing; when clear the link runs as a plain select-framed serial port.
// (RULE10) In mono format each transmit word goes out on both left and right channel; otherwise stereo.
// (RULE11) The audio mode field picks PCM/DSP (11), right justified (10), left justified (01) or I2S (00).
// (RULE12) Audio enable, mono format and audio mode take writes only while the module enable is 0.
// (RULE13) Mono format and audio mode act only while audio enable is 1.
// (RULE14) Unimplemented bits of the second control register, upper halfword included, read as zero.
// (RULE15) Overflow is a completed word meeting a full FIFO; underrun is a word due out with an empty buffer.
`ifndef SAE_DEFS_VH
`define SAE_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define SAE_ADDR_W      6
`define SAE_OFF_CTRL1   6'h00
`define SAE_OFF_CTRL2   6'h04
`define SAE_OFF_STAT    6'h08
`define SAE_OFF_MASK    6'h0c
`define SAE_OFF_TXB     6'h10
`define SAE_OFF_RXB     6'h14

// ****************************************
// Fields
// ****************************************
`define SAE_B_ON        15
`define SAE_B_SGNEXT    15
`define SAE_B_FRMEN     12
`define SAE_B_ROVEN     11
`define SAE_B_TUREN     10
`define SAE_B_IGNORE_RX_OVERFLOW    9
`define SAE_B_IGNORE_TX_UNDERRUN    8
`define SAE_B_AUDIO_PROTOCOL_ENABLE     7
`define SAE_B_MONO      3
`define SAE_MOD_HI      1
`define SAE_MOD_LO      0
`define SAE_CTRL2_RW    32'h00009f8b
`define SAE_CTRL2_FREE  32'h00009f00
`define SAE_CTRL2_LOCK  32'h0000008b
`define SAE_EV_W        3
`define SAE_EV_FRM      0
`define SAE_EV_ROV      1
`define SAE_EV_TUR      2
`define SAE_ST_HALT     8
`define SAE_ST_TXF      9
`define SAE_ST_RXC_LO   10
`define SAE_ST_RXC_HI   12

// ****************************************
// Framing
// ****************************************
`define SAE_MODE_I2S    2'h0
`define SAE_MODE_LJ     2'h1
`define SAE_MODE_RJ     2'h2
`define SAE_MODE_PCM    2'h3
`define SAE_WORD_W      16
`define SAE_LAST_BIT    4'hf
`define SAE_POS_W       6
`define SAE_POS_MAX     6'h3f
`define SAE_POS_ZERO    6'h00
`define SAE_START_I2S   6'h01
`define SAE_START_LJ    6'h00
`define SAE_START_RJ    6'h10
`define SAE_START_PCM_L 6'h01
`define SAE_START_PCM_R 6'h11

// ****************************************
// Receive FIFO
// ****************************************
`define SAE_DEPTH       4
`define SAE_PTR_W       2
`define SAE_CNT_W       3
`define SAE_FIFO_FULL   3'h4

`endif

/* logic/sae_pin_sync.v */
`timescale 1ns/10ps
module sae_pin_sync
#(
   parameter W = 3
)
(
   input  wire         clock,
   input  wire         reset,
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);

   genvar gi;

   // ****************************************
   // Three stages per pin, change taken on agreement
   // ****************************************
   generate
      for (gi = 0; gi < W; gi = gi + 1)
      begin : g_bit
         reg s1_r;
         reg s2_r;
         reg s3_r;
         reg q_r;
         always @(posedge clock)
         begin
            if (reset)
            begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               q_r  <= 1'b0;
            end
            else
            begin
               s1_r <= din[gi];
               s2_r <= s1_r;
               s3_r <= s2_r;
               // Glitch of one cycle never reaches the block
               if (s2_r == s3_r)
                  q_r <= s3_r;
            end
         end
         assign dout[gi] = q_r;
      end
   endgenerate

endmodule // sae_pin_sync

/* logic/sae_serial_control.v */
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "sae_defs.vh"
module sae_serial_control
(
   input  wire                   clock,
   input  wire                   reset,
   input  wire [`SAE_ADDR_W-1:0] addr,
   input  wire [31:0]            wr_data,
   input  wire                   wr_stb,
   input  wire                   rd_stb,
   output reg  [31:0]            rd_data_r,
   input  wire                   link_sck,
   input  wire                   link_fs,
   input  wire                   link_sdi,
   output reg                    link_sdo_r,
   output reg                    irq_r
);

   // ****************************************
   // Declarations
   // ****************************************
   wire [2:0]                   pin_s;
   wire                         sck_s;
   wire                         fs_s;
   wire                         sdi_s;
   reg                          sck_q_r;
   reg                          fs_q_r;
   reg                          on_r;
   reg  [31:0]                  ctrl2_r;
   reg  [`SAE_EV_W-1:0]         stat_r;
   reg  [`SAE_EV_W-1:0]         mask_r;
   reg                          halted_r;
   reg  [`SAE_WORD_W-1:0]       txb_r;
   reg                          txb_full_r;
   reg  [`SAE_PTR_W-1:0]        wp_r;
   reg  [`SAE_PTR_W-1:0]        rp_r;
   reg  [`SAE_CNT_W-1:0]        cnt_r;
   wire [`SAE_DEPTH*`SAE_WORD_W-1:0] fifo_flat;
   reg  [`SAE_WORD_W-1:0]       rx_sh_r;
   reg                          rx_busy_r;
   reg  [3:0]                   rx_idx_r;
   reg  [`SAE_WORD_W-1:0]       tx_sh_r;
   reg  [`SAE_WORD_W-1:0]       hold_r;
   reg  [3:0]                   tx_rem_r;
   reg                          pres_done_r;
   reg  [`SAE_POS_W-1:0]        pos_r;

   wire                         audio;
   wire [1:0]                   mode;
   wire                         mono;
   wire                         sck_rise;
   wire                         sck_fall;
   wire                         active;
   wire [`SAE_WORD_W-1:0]       head;
   wire [`SAE_WORD_W-1:0]       rx_word;

   reg                          frame_evt;
   reg                          spi_end;
   reg                          present;
   reg  [`SAE_POS_W-1:0]        pres_pos;
   reg                          right_chan;
   reg                          rx_take;
   reg                          rx_done;
   reg                          tx_load;
   reg                          tx_pop;
   reg                          push;
   reg                          pop;
   reg  [`SAE_EV_W-1:0]         raw_ev;
   reg  [`SAE_EV_W-1:0]         ev_set;
   reg                          crit;
   reg  [`SAE_EV_W-1:0]         ev_clr;

   // ****************************************
   // Pin synchroniser
   // ****************************************
   sae_pin_sync #(.W(3)) u_sync
   (
      .clock (clock),
      .reset (reset),
      .din   ({link_sdi, link_fs, link_sck}),
      .dout  (pin_s)
   );

   assign sck_s    = pin_s[0];
   assign fs_s     = pin_s[1];
   assign sdi_s    = pin_s[2];
   assign sck_rise = sck_s & ~sck_q_r;
   assign sck_fall = ~sck_s & sck_q_r;

   assign audio  = ctrl2_r[`SAE_B_AUDIO_PROTOCOL_ENABLE];                          // RULE9
   assign mode   = ctrl2_r[`SAE_MOD_HI:`SAE_MOD_LO];
   assign mono   = audio & ctrl2_r[`SAE_B_MONO];                   // RULE13
   // Plain mode is framed by an active-low select
   assign active = on_r & ~halted_r & (audio | ~fs_s);

   // ****************************************
   // Word start positions
   // ****************************************
   function word_start;
      input [`SAE_POS_W-1:0] p;
      input                  aud;
      input [1:0]            md;
      begin
         word_start = 1'b0;
         if (!aud)
            word_start = (p == `SAE_START_LJ);
         else
         begin
            case (md)                                              // RULE11
               `SAE_MODE_I2S: word_start = (p == `SAE_START_I2S);
               `SAE_MODE_LJ:  word_start = (p == `SAE_START_LJ);
               `SAE_MODE_RJ:  word_start = (p == `SAE_START_RJ);
               `SAE_MODE_PCM: word_start = (p == `SAE_START_PCM_L) | (p == `SAE_START_PCM_R);
               default:       word_start = 1'b0;
            endcase
         end
      end
   endfunction

   // ****************************************
   // Receive FIFO storage
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < `SAE_DEPTH; gi = gi + 1)
      begin : g_ent
         localparam integer IDX = gi;
         reg [`SAE_WORD_W-1:0] ent_r;
         always @(posedge clock)
         begin
            if (reset)
               ent_r <= {`SAE_WORD_W{1'b0}};
            else if (push && (wp_r == IDX[`SAE_PTR_W-1:0]))
               ent_r <= rx_word;
         end
         assign fifo_flat[gi*`SAE_WORD_W +: `SAE_WORD_W] = ent_r;
      end
   endgenerate

   assign head    = fifo_flat[rp_r*`SAE_WORD_W +: `SAE_WORD_W];
   assign rx_word = {rx_sh_r[`SAE_WORD_W-2:0], sdi_s};

   // ****************************************
   // Link events
   // ****************************************
   always @*
   begin
      frame_evt = 1'b0;
      spi_end   = 1'b0;
      if (on_r && !halted_r)
      begin
         if (!audio)
         begin
            frame_evt = ~fs_s & fs_q_r;
            spi_end   = fs_s & ~fs_q_r;
         end
         else if (mode == `SAE_MODE_PCM)
            frame_evt = fs_s & ~fs_q_r;
         else
            frame_evt = fs_s ^ fs_q_r;
      end
      // One present per bit slot; a frame edge always restarts at slot zero
      present  = frame_evt | (sck_fall & active & ~pres_done_r);
      pres_pos = frame_evt ? `SAE_POS_ZERO : pos_r;
      tx_load  = present & word_start(pres_pos, audio, mode);
      if (!audio)
         right_chan = 1'b0;
      else if (mode == `SAE_MODE_PCM)
         right_chan = (pres_pos == `SAE_START_PCM_R);
      else if (mode == `SAE_MODE_I2S)
         right_chan = fs_s;
      else
         right_chan = ~fs_s;
      rx_take = sck_rise & active & ~frame_evt & (rx_busy_r | word_start(pos_r, audio, mode));
      rx_done = rx_take & (rx_idx_r == `SAE_LAST_BIT);
      raw_ev  = {`SAE_EV_W{1'b0}};
      crit    = 1'b0;
      push    = 1'b0;
      tx_pop  = 1'b0;
      if ((frame_evt | spi_end) & rx_busy_r)
         raw_ev[`SAE_EV_FRM] = 1'b1;
      if (rx_done)
      begin
         if (cnt_r == `SAE_FIFO_FULL)                              // RULE15
         begin
            raw_ev[`SAE_EV_ROV] = 1'b1;
            crit = ~ctrl2_r[`SAE_B_IGNORE_RX_OVERFLOW];                        // RULE6
         end
         else
            push = 1'b1;                                           // RULE5
      end
      if (tx_load && !(mono && right_chan))                        // RULE10
      begin
         if (txb_full_r)
            tx_pop = 1'b1;
         else
         begin
            raw_ev[`SAE_EV_TUR] = 1'b1;                            // RULE15
            crit = crit | ~ctrl2_r[`SAE_B_IGNORE_TX_UNDERRUN];                 // RULE8
         end
      end
      ev_set[`SAE_EV_FRM] = raw_ev[`SAE_EV_FRM] & ctrl2_r[`SAE_B_FRMEN];   // RULE2
      ev_set[`SAE_EV_ROV] = raw_ev[`SAE_EV_ROV] & ctrl2_r[`SAE_B_ROVEN];   // RULE3
      ev_set[`SAE_EV_TUR] = raw_ev[`SAE_EV_TUR] & ctrl2_r[`SAE_B_TUREN];   // RULE4
      pop    = rd_stb & (addr == `SAE_OFF_RXB) & (cnt_r != {`SAE_CNT_W{1'b0}});
      ev_clr = (wr_stb && (addr == `SAE_OFF_STAT)) ? wr_data[`SAE_EV_W-1:0] : {`SAE_EV_W{1'b0}};
   end

   // ****************************************
   // Registers and bus
   // ****************************************
   always @(posedge clock)
   begin
      if (reset)
      begin
         on_r       <= 1'b0;
         ctrl2_r    <= 32'h00000000;
         stat_r     <= {`SAE_EV_W{1'b0}};
         mask_r     <= {`SAE_EV_W{1'b0}};
         halted_r   <= 1'b0;
         txb_r      <= {`SAE_WORD_W{1'b0}};
         txb_full_r <= 1'b0;
         wp_r       <= {`SAE_PTR_W{1'b0}};
         rp_r       <= {`SAE_PTR_W{1'b0}};
         cnt_r      <= {`SAE_CNT_W{1'b0}};
         rd_data_r  <= 32'h00000000;
         irq_r      <= 1'b0;
      end
      else
      begin
         if (wr_stb && (addr == `SAE_OFF_CTRL1))
            on_r <= wr_data[`SAE_B_ON];
         if (wr_stb && (addr == `SAE_OFF_CTRL2))
         begin
            // Framing fields locked while running
            if (!on_r)                                             // RULE12
               ctrl2_r <= wr_data & `SAE_CTRL2_RW;
            else
               ctrl2_r <= (wr_data & `SAE_CTRL2_FREE) | (ctrl2_r & `SAE_CTRL2_LOCK);
         end
         if (wr_stb && (addr == `SAE_OFF_MASK))
            mask_r <= wr_data[`SAE_EV_W-1:0];
         // Set wins over a write-one clear in the same cycle
         stat_r <= (stat_r & ~ev_clr) | ev_set;
         irq_r  <= |(stat_r & mask_r);
         if (!on_r)
            halted_r <= 1'b0;
         else if (crit)
            halted_r <= 1'b1;                                      // RULE6 RULE8
         if (!on_r)
            txb_full_r <= 1'b0;
         else if (wr_stb && (addr == `SAE_OFF_TXB) && (!txb_full_r || tx_pop))
         begin
            txb_r      <= wr_data[`SAE_WORD_W-1:0];
            txb_full_r <= 1'b1;
         end
         else if (tx_pop)
            txb_full_r <= 1'b0;
         // Disable flushes the FIFO so a restart sees no stale words
         if (!on_r)
         begin
            wp_r  <= {`SAE_PTR_W{1'b0}};
            rp_r  <= {`SAE_PTR_W{1'b0}};
            cnt_r <= {`SAE_CNT_W{1'b0}};
         end
         else
         begin
            if (push)
               wp_r <= wp_r + 1'b1;
            if (pop)
               rp_r <= rp_r + 1'b1;
            if (push && !pop)
               cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
               cnt_r <= cnt_r - 1'b1;
         end
         rd_data_r <= 32'h00000000;
         if (rd_stb)
         begin
            case (addr)
               `SAE_OFF_CTRL1: rd_data_r[`SAE_B_ON] <= on_r;
               `SAE_OFF_CTRL2: rd_data_r <= ctrl2_r & `SAE_CTRL2_RW;           // RULE14
               `SAE_OFF_STAT:
               begin
                  rd_data_r[`SAE_EV_W-1:0]                   <= stat_r;
                  rd_data_r[`SAE_ST_HALT]                    <= halted_r;
                  rd_data_r[`SAE_ST_TXF]                     <= txb_full_r;
                  rd_data_r[`SAE_ST_RXC_HI:`SAE_ST_RXC_LO]   <= cnt_r;
               end
               `SAE_OFF_MASK:  rd_data_r[`SAE_EV_W-1:0] <= mask_r;
               `SAE_OFF_RXB:
               begin
                  if (ctrl2_r[`SAE_B_SGNEXT])                                  // RULE1
                     rd_data_r <= {{(32-`SAE_WORD_W){head[`SAE_WORD_W-1]}}, head};
                  else
                     rd_data_r <= {{(32-`SAE_WORD_W){1'b0}}, head};
               end
               default:        rd_data_r <= 32'h00000000;
            endcase
         end
      end
   end

   // ****************************************
   // Serial shifting
   // ****************************************
   always @(posedge clock)
   begin
      if (reset)
      begin
         sck_q_r     <= 1'b0;
         fs_q_r      <= 1'b0;
         pos_r       <= `SAE_POS_ZERO;
         rx_sh_r     <= {`SAE_WORD_W{1'b0}};
         rx_busy_r   <= 1'b0;
         rx_idx_r    <= 4'h0;
         tx_sh_r     <= {`SAE_WORD_W{1'b0}};
         hold_r      <= {`SAE_WORD_W{1'b0}};
         tx_rem_r    <= 4'h0;
         pres_done_r <= 1'b0;
         link_sdo_r  <= 1'b0;
      end
      else
      begin
         sck_q_r <= sck_s;
         fs_q_r  <= fs_s;
         if (!on_r || halted_r)
         begin
            rx_busy_r  <= 1'b0;
            rx_idx_r   <= 4'h0;
            tx_rem_r   <= 4'h0;
            link_sdo_r <= 1'b0;
         end
         else
         begin
            if (frame_evt)
               pos_r <= `SAE_POS_ZERO;
            else if (sck_rise && active)
            begin
               if (!audio)
                  pos_r <= {2'b00, pos_r[3:0] + 4'h1};
               else if (pos_r != `SAE_POS_MAX)
                  pos_r <= pos_r + 6'h01;
            end
            if (frame_evt || spi_end)
            begin
               rx_busy_r <= 1'b0;
               rx_idx_r  <= 4'h0;
            end
            else if (rx_take)
            begin
               rx_sh_r   <= rx_word;
               rx_busy_r <= ~rx_done;
               rx_idx_r  <= rx_done ? 4'h0 : rx_idx_r + 4'h1;
            end
            if (sck_rise)
               pres_done_r <= 1'b0;
            else if (present)
               pres_done_r <= 1'b1;
            if (tx_load)
            begin
               tx_rem_r <= `SAE_LAST_BIT;
               if (mono && right_chan)
               begin
                  link_sdo_r <= hold_r[`SAE_WORD_W-1];
                  tx_sh_r    <= {hold_r[`SAE_WORD_W-2:0], 1'b0};
               end
               else if (txb_full_r)
               begin
                  link_sdo_r <= txb_r[`SAE_WORD_W-1];
                  tx_sh_r    <= {txb_r[`SAE_WORD_W-2:0], 1'b0};
                  hold_r     <= txb_r;
               end
               else
               begin
                  // Underrun word is all zeros
                  link_sdo_r <= 1'b0;                              // RULE7
                  tx_sh_r    <= {`SAE_WORD_W{1'b0}};
                  hold_r     <= {`SAE_WORD_W{1'b0}};
               end
            end
            else if (present)
            begin
               if (tx_rem_r != 4'h0)
               begin
                  link_sdo_r <= tx_sh_r[`SAE_WORD_W-1];
                  tx_sh_r    <= {tx_sh_r[`SAE_WORD_W-2:0], 1'b0};
                  tx_rem_r   <= tx_rem_r - 4'h1;
               end
               else
                  link_sdo_r <= 1'b0;
            end
         end
      end
   end

endmodule // sae_serial_control

/* sim/sae_properties.sv */
`timescale 1ns/10ps
`include "sae_defs.vh"
module sae_properties
(
   input wire                   clock,
   input wire                   reset,
   input wire [`SAE_ADDR_W-1:0] addr,
   input wire [31:0]            wr_data,
   input wire                   wr_stb,
   input wire                   rd_stb,
   input wire [31:0]            rd_data_r,
   input wire                   link_sck,
   input wire                   link_fs,
   input wire                   link_sdi,
   input wire                   link_sdo_r,
   input wire                   irq_r
);
   reg        on_r;
   reg [31:0] c2_r;
   reg [2:0]  mask_r;
   wire       rd_c2 = rd_stb && addr == `SAE_OFF_CTRL2;
   wire       rd_rx = rd_stb && addr == `SAE_OFF_RXB;
   // ******
   // Shadow of software writes, lock applied
   // ******
   always @(posedge clock)
   begin
      if (reset)
      begin
         on_r   <= 1'b0;
         c2_r   <= 32'h0;
         mask_r <= 3'h0;
      end
      else if (wr_stb)
      begin
         if (addr == `SAE_OFF_CTRL1)
            on_r <= wr_data[`SAE_B_ON];
         if (addr == `SAE_OFF_CTRL2)
            c2_r <= on_r ? ((c2_r & `SAE_CTRL2_LOCK) | (wr_data & `SAE_CTRL2_FREE)) : (wr_data & `SAE_CTRL2_RW);
         if (addr == `SAE_OFF_MASK)
            mask_r <= wr_data[2:0];
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   rd_idle_zero_a: assert property (!rd_stb |=> rd_data_r == 32'h0)
      else $error("read data not cleared");
   unmapped_zero_a: assert property (rd_stb && addr > `SAE_OFF_RXB |=> rd_data_r == 32'h0)
      else $error("unmapped read not zero");
   ctrl2_lock_a: assert property (rd_c2 |=> rd_data_r == c2_r)
      else $error("control two readback wrong");
   ctrl2_unused_a: assert property (rd_c2 |=> (rd_data_r & ~`SAE_CTRL2_RW) == 32'h0)
      else $error("unused control bits set");
   sign_ext_a: assert property (rd_rx && c2_r[`SAE_B_SGNEXT] |=> rd_data_r[31:16] == {16{rd_data_r[15]}})
      else $error("receive word not sign extended");
   zero_ext_a: assert property (rd_rx && !c2_r[`SAE_B_SGNEXT] |=> rd_data_r[31:16] == 16'h0)
      else $error("receive word extended");
   irq_mask_a: assert property ((mask_r == 3'h0) [*2] |-> !irq_r)
      else $error("interrupt with all masked");
   irq_flag_a: assert property (rd_stb && addr == `SAE_OFF_STAT |=> |(rd_data_r[2:0] & mask_r) |-> irq_r)
      else $error("interrupt missing");
   sdo_off_a: assert property ((!on_r) [*3] |-> !link_sdo_r)
      else $error("data out while disabled");
   sext_c: cover property (rd_rx && c2_r[`SAE_B_SGNEXT]);
   irq_c: cover property (irq_r);
   lock_c: cover property (wr_stb && addr == `SAE_OFF_CTRL2 && on_r);
endmodule // sae_properties

bind sae_serial_control sae_properties chk
(
   .clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rd_data_r(rd_data_r), .link_sck(link_sck), .link_fs(link_fs), .link_sdi(link_sdi),
   .link_sdo_r(link_sdo_r), .irq_r(irq_r)
);

/* sim/sae_codec_model.sv */
`timescale 1ns/10ps
module sae_codec_model
(
   output reg  link_sck,
   output reg  link_fs,
   output reg  link_sdi,
   input  wire link_sdo
);
   localparam HALF = 400;
   reg [15:0] sh;
   integer    p;
   initial
   begin
      link_sck = 1'b0;
      link_fs  = 1'b1;
      link_sdi = 1'b0;
   end
   // ******
   // Frames; sdo read at the next fall, as it trails sck
   // ******
   task word(input [15:0] din, input integer n, output [15:0] dout);
      begin
         #13;
         sh       = din;
         link_fs  = 1'b0;
         link_sdi = sh[15];
         #(2*HALF);
         for (p = 15; p > 15 - n; p = p - 1)
         begin
            link_sck = 1'b1;
            #HALF;
            dout[p]  = link_sdo;
            link_sck = 1'b0;
            sh       = {sh[14:0], ~sh[0]};
            link_sdi = sh[15];
            #HALF;
         end
         #(2*HALF);
         link_fs = 1'b1;
         link_sdi = ~link_sdi;
         #(2*HALF);
      end
   endtask
   task i2s(output [15:0] lw, output [15:0] rw);
      begin
         #13;
         link_fs = 1'b0;
         #HALF;
         for (p = 0; p < 64; p = p + 1)
         begin
            link_sck = 1'b1;
            #HALF;
            if (p >= 1 && p <= 16)
               lw = {lw[14:0], link_sdo};
            if (p >= 33 && p <= 48)
               rw = {rw[14:0], link_sdo};
            link_sck = 1'b0;
            link_sdi = ~link_sdi;
            link_fs  = (p >= 31);
            #HALF;
         end
         #(2*HALF);
      end
   endtask
endmodule // sae_codec_model

/* sim/tb_top.sv */
`timescale 1ns/10ps
`include "sae_defs.vh"
module tb_top;
   reg         clock;
   reg         reset;
   reg  [5:0]  addr;
   reg  [31:0] wr_data;
   reg         wr_stb;
   reg         rd_stb;
   wire [31:0] rd_data;
   wire        sck, fs, sdi, sdo, irq;
   integer     n_mismatch, n_checks, cycles, i;
   reg  [15:0] lw, rw;
   reg  [79:0] words;
   sae_serial_control uut
   (
      .clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data_r(rd_data), .link_sck(sck), .link_fs(fs), .link_sdi(sdi), .link_sdo_r(sdo), .irq_r(irq)
   );
   sae_codec_model codec (.link_sck(sck), .link_fs(fs), .link_sdi(sdi), .link_sdo(sdo));
   always #50 clock = ~clock;
   // ******
   // Shared tasks
   // ******
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   always @(posedge clock)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         finish_test;
      end
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // Trailing idle cycle keeps strobes from being set twice in one step
   task wr(input [5:0] a, input [31:0] d);
      begin
         addr    <= a;
         wr_data <= d;
         wr_stb  <= 1'b1;
         @(posedge clock);
         wr_stb  <= 1'b0;
         @(posedge clock);
      end
   endtask
   task rd_chk(input [5:0] a, input [31:0] e);
      begin
         addr   <= a;
         rd_stb <= 1'b1;
         @(posedge clock);
         rd_stb <= 1'b0;
         @(posedge clock);
         check(rd_data, e);
      end
   endtask
   task cfg(input [31:0] c2);
      begin
         wr(`SAE_OFF_CTRL1, 32'h0);
         wr(`SAE_OFF_CTRL2, c2);
         wr(`SAE_OFF_CTRL1, 32'h8000);
      end
   endtask
   task frame(input [15:0] d, input integer n);
      begin
         codec.word(d, n, lw);
         @(posedge clock);
      end
   endtask
   // ******
   // Scenarios
   // ******
   task t_regs;
      begin
         rd_chk(`SAE_OFF_CTRL2, 32'h0);
         wr(`SAE_OFF_CTRL2, 32'hffffffff);
         rd_chk(`SAE_OFF_CTRL2, 32'h00009f8b);
         for (i = 0; i < 4; i = i + 1)
         begin
            wr(`SAE_OFF_CTRL2, 32'h80 | i);
            rd_chk(`SAE_OFF_CTRL2, 32'h80 | i);
         end
         wr(`SAE_OFF_CTRL1, 32'h8000);
         wr(`SAE_OFF_CTRL2, 32'h0);
         rd_chk(`SAE_OFF_CTRL2, 32'h83);
         rd_chk(6'h18, 32'h0);
      end
   endtask
   task t_plain;
      begin
         cfg(32'h108);
         wr(`SAE_OFF_TXB, 32'hc3a5);
         frame(16'h9e2d, 16);
         check({16'h0, lw}, 32'hc3a5);
         rd_chk(`SAE_OFF_RXB, 32'h00009e2d);
      end
   endtask
   task t_under;
      begin
         wr(`SAE_OFF_MASK, 32'h4);
         cfg(32'h500);
         frame(16'h0f0f, 16);
         check({16'h0, lw}, 32'h0);
         rd_chk(`SAE_OFF_STAT, 32'h404);
         check({31'h0, irq}, 32'h1);
         wr(`SAE_OFF_STAT, 32'h4);
         rd_chk(`SAE_OFF_STAT, 32'h400);
         check({31'h0, irq}, 32'h0);
         cfg(32'h0);
         frame(16'h0f0f, 16);
         rd_chk(`SAE_OFF_STAT, 32'h100);
      end
   endtask
   task t_ferr;
      begin
         cfg(32'h1100);
         wr(`SAE_OFF_TXB, 32'h1234);
         frame(16'h00ff, 5);
         rd_chk(`SAE_OFF_STAT, 32'h1);
         check({31'h0, irq}, 32'h0);
         wr(`SAE_OFF_STAT, 32'h7);
      end
   endtask
   task t_over;
      begin
         cfg(32'h8b00);
         words = {16'h8a5c, 16'h1234, 16'hf00f, 16'h7e81, 16'h5555};
         for (i = 4; i >= 0; i = i - 1)
            frame(words[16*i +: 16], 16);
         rd_chk(`SAE_OFF_STAT, 32'h1002);
         wr(`SAE_OFF_CTRL2, 32'h8900);
         frame(16'h6666, 16);
         rd_chk(`SAE_OFF_STAT, 32'h1102);
         rd_chk(`SAE_OFF_RXB, 32'hffff8a5c);
         rd_chk(`SAE_OFF_RXB, 32'h00001234);
         wr(`SAE_OFF_CTRL2, 32'h0900);
         rd_chk(`SAE_OFF_RXB, 32'h0000f00f);
         rd_chk(`SAE_OFF_RXB, 32'h00007e81);
      end
   endtask
   task t_audio;
      begin
         cfg(32'h388);
         wr(`SAE_OFF_TXB, 32'h9b37);
         codec.i2s(lw, rw);
         @(posedge clock);
         check({16'h0, lw}, 32'h9b37);
         check({16'h0, rw}, 32'h9b37);
         cfg(32'h383);
         wr(`SAE_OFF_TXB, 32'h4c71);
         codec.i2s(lw, rw);
         @(posedge clock);
         check({16'h0, lw}, 32'h0);
         check({16'h0, rw}, 32'h4c71);
      end
   endtask
   initial
   begin
      clock      = 1'b0;
      reset      = 1'b1;
      addr       = 6'h0;
      wr_data    = 32'h0;
      wr_stb     = 1'b0;
      rd_stb     = 1'b0;
      n_mismatch = 0;
      n_checks   = 0;
      cycles     = 0;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      repeat (2) @(posedge clock);
      t_regs;
      t_plain;
      t_under;
      t_ferr;
      t_over;
      t_audio;
      finish_test;
   end
endmodule // tb_top
